// file: hdl/pmcs_defines.vh
// Constants for the power-managed clock status block
`ifndef PMCS_DEFINES_VH
`define PMCS_DEFINES_VH

// ****************************************
// Register map (Avalon word addresses, byte = 4 x index)
// ****************************************
`define PMCS_ADDR_W        3
`define PMCS_REG_CTRL      3'h0
`define PMCS_REG_STATUS    3'h1
`define PMCS_REG_CMD       3'h2
`define PMCS_REG_CONFIG    3'h3

// ****************************************
// Control register fields
// ****************************************
`define PMCS_CTRL_SRC_LSB  0
`define PMCS_CTRL_IDLE_BIT 7
`define PMCS_CTRL_RST      8'h00

// ****************************************
// Clock source select encodings
// ****************************************
`define PMCS_SRC_PRIMARY   2'h0
`define PMCS_SRC_SECONDARY 2'h1
`define PMCS_SRC_INTERNAL  2'h2
`define PMCS_SRC_INTERNAL2 2'h3

// ****************************************
// Oscillator configuration field: internal-block-as-primary code and reset value
// ****************************************
`define PMCS_CFG_INT_PRI   4'h8
`define PMCS_CFG_RST       4'h2

// ****************************************
// Status bit positions
// ****************************************
`define PMCS_ST_PRI_BIT    3
`define PMCS_ST_INT_BIT    2
`define PMCS_ST_SEC_BIT    6
`define PMCS_ST_BUSY_BIT   0
`define PMCS_ST_IDLE_BIT   4
`define PMCS_ST_SLEEP_BIT  5

// ****************************************
// Switch timing in source cycles
// ****************************************
`define PMCS_OLD_CYCLES    2
`define PMCS_NEW_CYCLES    4
// Reference edges before the two-speed strap synchroniser holds a valid value
`define PMCS_STRAP_WAIT    2'h2

`endif

// file: hdl/pmcs_edge_count.v
// Counts rising edges of a synchronised oscillator tick, saturating at all ones
`timescale 1ns/1ps
`default_nettype none

module pmcs_edge_count #(
  parameter WIDTH = 3
) (
  input  wire             i_ref_clk,
  input  wire             i_srst,
  input  wire             i_clear,
  input  wire             i_tick_async,
  output wire [WIDTH-1:0] o_count
);

  reg             sync1_ff;
  reg             sync2_ff;
  reg             prev_ff;
  reg [WIDTH-1:0] cnt_ff;

  // ****************************************
  // Two-flop synchroniser, edge detect on the second flop only
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
      cnt_ff   <= {WIDTH{1'b0}};
    end else begin
      sync1_ff <= i_tick_async;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
      // Saturate so a slow clear never wraps the count
      if (i_clear)
        cnt_ff <= {WIDTH{1'b0}};
      else if (sync2_ff && !prev_ff && !(&cnt_ff))
        cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign o_count = cnt_ff;

endmodule // pmcs_edge_count

`default_nettype wire

// file: hdl/pmcs_clock_status.v
// Power-managed clock source selection, switch timing and status flags
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pmcs_defines.vh"

module pmcs_clock_status #(
  parameter OLD_CYCLES = `PMCS_OLD_CYCLES,
  parameter NEW_CYCLES = `PMCS_NEW_CYCLES
) (
  input  wire                     i_ref_clk,
  input  wire                     i_srst,
  // Avalon-MM slave
  input  wire [`PMCS_ADDR_W-1:0]  i_avs_address,
  input  wire                     i_avs_read,
  input  wire                     i_avs_write,
  input  wire [31:0]              i_avs_writedata,
  output reg  [31:0]              o_avs_readdata,
  output wire                     o_avs_waitrequest,
  // Oscillator side (asynchronous)
  input  wire                     i_pri_osc_tick,
  input  wire                     i_sec_osc_tick,
  input  wire                     i_int_osc_tick,
  input  wire                     i_int_osc_stable,
  input  wire                     i_pri_osc_ready,
  input  wire                     i_two_speed_en,
  // Core side
  input  wire                     i_powerdown,
  input  wire                     i_wake,
  output reg                      o_pri_osc_en,
  output reg  [1:0]               o_clk_sel,
  output reg                      o_cpu_clk_en,
  output reg                      o_periph_clk_en
);

  localparam ST_RUN    = 2'h0;
  localparam ST_OLD    = 2'h1;
  localparam ST_NEW    = 2'h2;
  localparam ST_SLEEP  = 2'h3;

  reg  [7:0] ctrl_ff;
  reg  [3:0] osc_cfg_ff;
  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg  [1:0] cur_src_ff;
  reg  [1:0] tgt_src_ff;
  reg        idle_ff;
  reg        pri_flag_ff;
  reg        int_flag_ff;
  reg        sec_flag_ff;
  reg        cfg_seen_ff;
  reg  [1:0] cfg_wait_ff;
  reg        stab1_ff;
  reg        stab2_ff;
  reg        rdy1_ff;
  reg        rdy2_ff;
  reg        ts1_ff;
  reg        ts2_ff;
  reg        clr_cnt;
  reg        old_tick;
  reg        new_tick;
  wire [2:0] cnt_pri;
  wire [2:0] cnt_sec;
  wire [2:0] cnt_int;
  wire [1:0] sel_src;
  wire       idle_sel;
  wire       int_as_pri;
  wire [2:0] old_cnt;
  wire [2:0] new_cnt;
  wire       new_ready;

  assign sel_src    = ctrl_ff[`PMCS_CTRL_SRC_LSB +: 2];
  assign idle_sel   = ctrl_ff[`PMCS_CTRL_IDLE_BIT];
  assign int_as_pri = (osc_cfg_ff == `PMCS_CFG_INT_PRI);

  // Registers answer in the same cycle, so no wait state is needed
  assign o_avs_waitrequest = 1'b0;

  // ****************************************
  // Oscillator edge counters
  // ****************************************
  pmcs_edge_count #(.WIDTH(3)) u_cnt_pri (
    .i_ref_clk    (i_ref_clk),
    .i_srst       (i_srst),
    .i_clear      (clr_cnt),
    .i_tick_async (i_pri_osc_tick),
    .o_count      (cnt_pri)
  );

  pmcs_edge_count #(.WIDTH(3)) u_cnt_sec (
    .i_ref_clk    (i_ref_clk),
    .i_srst       (i_srst),
    .i_clear      (clr_cnt),
    .i_tick_async (i_sec_osc_tick),
    .o_count      (cnt_sec)
  );

  pmcs_edge_count #(.WIDTH(3)) u_cnt_int (
    .i_ref_clk    (i_ref_clk),
    .i_srst       (i_srst),
    .i_clear      (clr_cnt),
    .i_tick_async (i_int_osc_tick),
    .o_count      (cnt_int)
  );

  // Pick the counts belonging to the outgoing and incoming source
  function [2:0] pick_cnt;
    input [1:0] src;
    input [2:0] cp;
    input [2:0] cs;
    input [2:0] ci;
    begin
      case (src)
        `PMCS_SRC_PRIMARY:   pick_cnt = cp;
        `PMCS_SRC_SECONDARY: pick_cnt = cs;
        default:             pick_cnt = ci;
      endcase
    end
  endfunction

  assign old_cnt = pick_cnt(cur_src_ff, cnt_pri, cnt_sec, cnt_int);
  assign new_cnt = pick_cnt(tgt_src_ff, cnt_pri, cnt_sec, cnt_int);
  // New source must be ready before the switch completes; the secondary needs no ready signal
  assign new_ready = (tgt_src_ff == `PMCS_SRC_PRIMARY)   ? (rdy2_ff || int_as_pri) :
                     (tgt_src_ff == `PMCS_SRC_SECONDARY) ? 1'b1 : stab2_ff;

  // ****************************************
  // Level synchronisers for oscillator status pins and the two-speed strap
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      stab1_ff <= 1'b0;
      stab2_ff <= 1'b0;
      rdy1_ff  <= 1'b0;
      rdy2_ff  <= 1'b0;
      ts1_ff   <= 1'b0;
      ts2_ff   <= 1'b0;
    end else begin
      stab1_ff <= i_int_osc_stable;
      stab2_ff <= stab1_ff;
      rdy1_ff  <= i_pri_osc_ready;
      rdy2_ff  <= rdy1_ff;
      ts1_ff   <= i_two_speed_en;
      ts2_ff   <= ts1_ff;
    end
  end

  // ****************************************
  // Avalon register writes and read mux
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctrl_ff    <= `PMCS_CTRL_RST;
      osc_cfg_ff <= `PMCS_CFG_RST;
    end else if (i_avs_write) begin
      if (i_avs_address == `PMCS_REG_CTRL)
        ctrl_ff <= i_avs_writedata[7:0];
      else if (i_avs_address == `PMCS_REG_CONFIG)
        osc_cfg_ff <= i_avs_writedata[3:0];
    end
  end

  always @* begin
    o_avs_readdata = 32'h0000_0000;
    case (i_avs_address)
      `PMCS_REG_CTRL:   o_avs_readdata = {24'h00_0000, ctrl_ff};
      `PMCS_REG_CONFIG: o_avs_readdata = {28'h000_0000, osc_cfg_ff};
      `PMCS_REG_STATUS: begin
        o_avs_readdata[`PMCS_ST_PRI_BIT]   = pri_flag_ff;
        o_avs_readdata[`PMCS_ST_INT_BIT]   = int_flag_ff;
        o_avs_readdata[`PMCS_ST_SEC_BIT]   = sec_flag_ff;
        o_avs_readdata[`PMCS_ST_BUSY_BIT]  = (state_ff == ST_OLD) || (state_ff == ST_NEW);
        o_avs_readdata[`PMCS_ST_IDLE_BIT]  = idle_ff;
        o_avs_readdata[`PMCS_ST_SLEEP_BIT] = (state_ff == ST_SLEEP);
      end
      default:          o_avs_readdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Switch sequencer next state
  // ****************************************
  always @* begin
    nxt_state = state_ff;
    clr_cnt   = 1'b0;
    old_tick  = (old_cnt >= OLD_CYCLES[2:0]);
    new_tick  = (new_cnt >= NEW_CYCLES[2:0]);
    case (state_ff)
      ST_RUN: begin
        // Power-down wins over a pending switch
        if (i_powerdown && !idle_sel)
          nxt_state = ST_SLEEP;
        else if (!i_powerdown && !idle_ff && sel_src != cur_src_ff) begin
          nxt_state = ST_OLD;
          clr_cnt   = 1'b1;
        end
      end
      ST_OLD: if (old_tick) begin
        nxt_state = ST_NEW;
        clr_cnt   = 1'b1;
      end
      ST_NEW: if (new_ready && new_tick)
        nxt_state = ST_RUN;
      ST_SLEEP: if (i_wake) begin
        nxt_state = ST_NEW;
        clr_cnt   = 1'b1;
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  // ****************************************
  // Sequencer, source tracking and status flags
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_ff        <= ST_NEW;
      cur_src_ff      <= `PMCS_SRC_PRIMARY;
      tgt_src_ff      <= `PMCS_SRC_PRIMARY;
      idle_ff         <= 1'b0;
      pri_flag_ff     <= 1'b0;
      int_flag_ff     <= 1'b0;
      sec_flag_ff     <= 1'b0;
      cfg_seen_ff     <= 1'b0;
      cfg_wait_ff     <= 2'h0;
      o_pri_osc_en    <= 1'b1;
      o_clk_sel       <= `PMCS_SRC_INTERNAL;
      o_cpu_clk_en    <= 1'b0;
      o_periph_clk_en <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // Two-speed start-up: run from internal while primary warms up
      // The strap is read only once its two-flop synchroniser has filled
      if (!cfg_seen_ff) begin
        if (cfg_wait_ff == `PMCS_STRAP_WAIT) begin
          cfg_seen_ff <= 1'b1;
          if (ts2_ff)
            tgt_src_ff <= `PMCS_SRC_INTERNAL;
        end else begin
          cfg_wait_ff <= cfg_wait_ff + 2'h1;
        end
      end
      if (state_ff == ST_RUN && nxt_state == ST_OLD)
        tgt_src_ff <= sel_src;
      // Idle entry stops only the CPU, flags are left alone
      if (state_ff == ST_RUN && i_powerdown && idle_sel) begin
        idle_ff      <= 1'b1;
        o_cpu_clk_en <= 1'b0;
      end
      if (i_wake && idle_ff) begin
        idle_ff      <= 1'b0;
        o_cpu_clk_en <= 1'b1;
      end
      if (nxt_state == ST_SLEEP) begin
        // Sleep stops both core clocks and clears every flag together
        o_cpu_clk_en    <= 1'b0;
        o_periph_clk_en <= 1'b0;
        pri_flag_ff     <= 1'b0;
        int_flag_ff     <= 1'b0;
        sec_flag_ff     <= 1'b0;
        tgt_src_ff      <= sel_src;
      end
      // Mux select moves only at completion, so it never runs ahead of the flags
      if (state_ff == ST_NEW && nxt_state == ST_RUN) begin
        cur_src_ff      <= tgt_src_ff;
        o_clk_sel       <= tgt_src_ff;
        o_cpu_clk_en    <= 1'b1;
        o_periph_clk_en <= 1'b1;
        o_pri_osc_en    <= (tgt_src_ff == `PMCS_SRC_PRIMARY);
        // All flags written in the completing cycle, never piecemeal
        pri_flag_ff <= (tgt_src_ff == `PMCS_SRC_PRIMARY);
        sec_flag_ff <= (tgt_src_ff == `PMCS_SRC_SECONDARY);
        int_flag_ff <= stab2_ff &&
                       ((tgt_src_ff[1]) ||
                        (tgt_src_ff == `PMCS_SRC_PRIMARY && int_as_pri));
      end else if (state_ff == ST_RUN && !idle_ff) begin
        // Internal block losing stability drops its flag at once
        if (!stab2_ff && (cur_src_ff[1] || int_as_pri))
          int_flag_ff <= 1'b0;
      end
      // Primary oscillator requested during the switch back to it
      if (state_ff == ST_OLD && tgt_src_ff == `PMCS_SRC_PRIMARY)
        o_pri_osc_en <= 1'b1;
    end
  end

endmodule // pmcs_clock_status

`default_nettype wire

// file: tb/pmcs_osc_model.sv
// Behavioural oscillator sources facing the clock status block
`timescale 1ns/1ps
`default_nettype none
module pmcs_osc_model (
  input  wire logic i_pri_en,
  input  wire logic i_int_ok,
  output var  logic o_pri_tick,
  output var  logic o_sec_tick,
  output var  logic o_int_tick,
  output wire logic o_int_stable,
  output var  logic o_pri_ready
);
  // ****************************************
  // Sources
  // ****************************************
  // All ticks start low; half periods stay above two reference cycles
  initial begin
    o_pri_tick  = 1'b0;
    o_sec_tick  = 1'b0;
    o_int_tick  = 1'b0;
    o_pri_ready = 1'b0;
  end
  // Primary stands still while disabled, as a stopped crystal would
  always #15 o_pri_tick = (i_pri_en === 1'b1) ? ~o_pri_tick : 1'b0;
  always #25 o_sec_tick = ~o_sec_tick;
  always #20 o_int_tick = ~o_int_tick;
  // Start-up delay keeps a switch back to primary from being instant
  always begin
    wait (i_pri_en === 1'b1);
    #200 o_pri_ready = i_pri_en;
    wait (i_pri_en !== 1'b1);
    o_pri_ready = 1'b0;
  end
  // Stability is commanded by the bench so a loss of lock can be staged
  assign o_int_stable = i_int_ok;
endmodule // pmcs_osc_model
`default_nettype wire

// file: tb/pmcs_clock_status_asserts.sv
// Port-level assertions for the clock status block
`timescale 1ns/1ps
`default_nettype none
module pmcs_clock_status_asserts #(
  parameter OLD_CYCLES = 2,
  parameter NEW_CYCLES = 4
) (
  input wire logic        i_ref_clk,
  input wire logic        i_srst,
  input wire logic [2:0]  i_avs_address,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_two_speed_en,
  input wire logic        i_powerdown,
  input wire logic [1:0]  o_clk_sel,
  input wire logic        o_cpu_clk_en,
  input wire logic        o_periph_clk_en
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  // Status is watched only while the address points at it
  logic       idle_sel_ff;
  wire        st_vis = (i_avs_address == 3'h1);
  wire  [2:0] flg    = {o_avs_readdata[6], o_avs_readdata[3], o_avs_readdata[2]};
  wire        busy   = o_avs_readdata[0];
  wire        pd_run = i_powerdown && o_cpu_clk_en && !i_avs_write;
  // Mirror of the idle select bit, as the core holds it at power-down
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) idle_sel_ff <= 1'b0;
    else if (i_avs_write && i_avs_address == 3'h0) idle_sel_ff <= i_avs_writedata[7];
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  property p_no_wait; o_avs_waitrequest == 1'b0; endproperty
  a_no_wait: assert property (p_no_wait) else $error("waitrequest raised");
  property p_run_both; o_cpu_clk_en |-> o_periph_clk_en; endproperty
  a_run_both: assert property (p_run_both) else $error("cpu clock without peripheral clock");
  property p_sleep; pd_run && !idle_sel_ff |=> !o_cpu_clk_en && !o_periph_clk_en; endproperty
  a_sleep: assert property (p_sleep) else $error("power-down did not stop all clocks");
  property p_idle; pd_run && idle_sel_ff |=> !o_cpu_clk_en && o_periph_clk_en && $stable(o_clk_sel); endproperty
  a_idle: assert property (p_idle) else $error("idle entry wrong");
  property p_boot; $fell(i_srst) && !i_two_speed_en |-> ##[1:400] o_cpu_clk_en && o_clk_sel == 2'h0; endproperty
  a_boot: assert property (p_boot) else $error("no primary run after reset");
  property p_boot_ts; $fell(i_srst) && i_two_speed_en |-> ##[1:400] o_cpu_clk_en && o_clk_sel[1]; endproperty
  a_boot_ts: assert property (p_boot_ts) else $error("two-speed start did not run from internal");
  property p_pri_flag; st_vis && o_cpu_clk_en && o_clk_sel == 2'h0 |-> flg[1] && !flg[2]; endproperty
  a_pri_flag: assert property (p_pri_flag) else $error("primary flag wrong");
  property p_sec_flag; st_vis && o_periph_clk_en && o_clk_sel == 2'h1 |-> flg == 3'b100; endproperty
  a_sec_flag: assert property (p_sec_flag) else $error("secondary flags wrong");
  property p_int_flag; st_vis && o_periph_clk_en && o_clk_sel[1] |-> !flg[1] && !flg[2]; endproperty
  a_int_flag: assert property (p_int_flag) else $error("internal flags wrong");
  property p_off_flags; st_vis && !o_periph_clk_en |-> flg == 3'b000; endproperty
  a_off_flags: assert property (p_off_flags) else $error("flags set while unclocked");
  property p_one_step; st_vis && $past(st_vis) && flg != $past(flg) |=> !st_vis || $stable(flg); endproperty
  a_one_step: assert property (p_one_step) else $error("flags changed in two steps");
  property p_busy_len; st_vis && $past(st_vis) && $rose(busy) |-> (busy || !st_vis) [*8]; endproperty
  a_busy_len: assert property (p_busy_len) else $error("switch finished too soon");
endmodule // pmcs_clock_status_asserts
bind pmcs_clock_status pmcs_clock_status_asserts #(
  .OLD_CYCLES(OLD_CYCLES),
  .NEW_CYCLES(NEW_CYCLES)
) u_asserts (
  .i_ref_clk, .i_srst, .i_avs_address, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
  .o_avs_waitrequest, .i_two_speed_en, .i_powerdown, .o_clk_sel, .o_cpu_clk_en, .o_periph_clk_en
);
`default_nettype wire

// file: tb/power_managed_clock_status_tb.sv
// Self-checking bench for the clock status block
`timescale 1ns/1ps
`default_nettype none
module power_managed_clock_status_tb;
  logic        clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, pd = 1'b0, wake = 1'b0, int_ok = 1'b1, ts = 1'b0;
  logic [2:0]  addr = 3'h1;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        waitreq, pri_en, cpu_en, per_en, pri_tick, sec_tick, int_tick, int_stable, pri_ready;
  logic [1:0]  clk_sel;
  logic [1:0]  srcs [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [31:0] exps [4] = '{32'h40, 32'h04, 32'h04, 32'h08};
  int          num_errors = 0, checks_done = 0, i;
  // 200 MHz reference
  always #2.5 clk = ~clk;
  pmcs_clock_status dut (
    .i_ref_clk(clk), .i_srst(srst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_pri_osc_tick(pri_tick), .i_sec_osc_tick(sec_tick), .i_int_osc_tick(int_tick),
    .i_int_osc_stable(int_stable), .i_pri_osc_ready(pri_ready), .i_two_speed_en(ts),
    .i_powerdown(pd), .i_wake(wake), .o_pri_osc_en(pri_en), .o_clk_sel(clk_sel),
    .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en)
  );
  pmcs_osc_model u_osc (
    .i_pri_en(pri_en), .i_int_ok(int_ok), .o_pri_tick(pri_tick), .o_sec_tick(sec_tick),
    .o_int_tick(int_tick), .o_int_stable(int_stable), .o_pri_ready(pri_ready)
  );
  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One Avalon transfer; held until waitrequest is sampled low, read data lands in d
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    d = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 3'h1;
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
  endtask
  // Poll until no switch is pending, then compare flags and mode bits
  task automatic settle(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      bus(1'b0, 3'h1, 32'h0);
      n++;
    end while (d[0] !== 1'b0 && n < 400);
    chk("status", exp, d & 32'h7D);
    if (n >= 400) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    while (cpu_en !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) begin
      num_errors++;
      finish_test();
    end
  endtask
  // One-cycle pulse on power-down (1) or wake (0)
  task automatic pulse(input logic sel);
    @(posedge clk);
    if (sel) pd <= 1'b1;
    else wake <= 1'b1;
    @(posedge clk);
    pd <= 1'b0;
    wake <= 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    wait_run();
    settle(32'h08);
    chk("periph_en", 32'h1, {31'h0, per_en});
    // Unmapped and command places read zero and ignore writes
    for (i = 2; i < 8; i++) if (i != 3) bus(1'b1, i[2:0], 32'hFFFFFFFF);
    for (i = 2; i < 8; i++) if (i != 3) begin
      bus(1'b0, i[2:0], 32'h0);
      chk("unmapped", 32'h0, d);
    end
    bus(1'b0, 3'h0, 32'h0);
    chk("ctrl", 32'h0, d);
    bus(1'b0, 3'h3, 32'h0);
    chk("config", 32'h2, d);
    $display("test reset done");
    // Every source code in turn, back to primary last
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 3'h0, {30'h0, srcs[i]});
      settle(exps[i]);
      chk("clk_sel", {30'h0, srcs[i]}, {30'h0, clk_sel});
      if (i == 0) chk("pri_en", 32'h0, {31'h0, pri_en});
    end
    $display("test sources done");
    // Internal block as primary, then plain internal at the same rate
    bus(1'b1, 3'h3, 32'h8);
    bus(1'b1, 3'h0, 32'h2);
    settle(32'h04);
    bus(1'b1, 3'h0, 32'h0);
    settle(32'h0C);
    bus(1'b1, 3'h0, 32'h2);
    settle(32'h04);
    @(posedge clk);
    int_ok <= 1'b0;
    repeat (10) @(posedge clk);
    bus(1'b0, 3'h1, 32'h0);
    chk("unstable", 32'h0, d & 32'h4C);
    int_ok <= 1'b1;
    bus(1'b1, 3'h3, 32'h2);
    bus(1'b1, 3'h0, 32'h0);
    settle(32'h08);
    $display("test internal done");
    // Idle, then sleep after the select bit is cleared
    bus(1'b1, 3'h0, 32'h80);
    pulse(1'b1);
    @(posedge clk);
    chk("idle_cpu", 32'h0, {31'h0, cpu_en});
    chk("idle_periph", 32'h1, {31'h0, per_en});
    bus(1'b0, 3'h1, 32'h0);
    chk("idle_flags", 32'h08, d & 32'h4C);
    pulse(1'b0);
    wait_run();
    bus(1'b1, 3'h0, 32'h0);
    pulse(1'b1);
    @(posedge clk);
    chk("sleep_en", 32'h0, {30'h0, cpu_en, per_en});
    bus(1'b0, 3'h1, 32'h0);
    chk("sleep_flags", 32'h0, d & 32'h4C);
    pulse(1'b0);
    wait_run();
    settle(32'h08);
    $display("test powerdown done");
    // Reset in mid-run from the secondary source
    bus(1'b1, 3'h0, 32'h1);
    settle(32'h40);
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    wait_run();
    chk("clk_sel", 32'h0, {30'h0, clk_sel});
    settle(32'h08);
    $display("test rereset done");
    // Two-speed start-up boots on internal, then moves on to the selected primary
    ts <= 1'b1;
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    wait_run();
    chk("ts_sel", 32'h2, {30'h0, clk_sel});
    bus(1'b0, 3'h1, 32'h0);
    chk("ts_flags", 32'h04, d & 32'h4C);
    settle(32'h08);
    ts <= 1'b0;
    $display("test two-speed done");
    finish_test();
  end
endmodule // power_managed_clock_status_tb
`default_nettype wire
